// >>> include/dsw_pkg.sv
package dsw_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int PM_AW = 12;
    localparam int WIN_OFS_W = 6;
    localparam int WIN_BASE_W = 6;
    localparam int RAM_BYTES = 60;
    localparam int IDX_REGS = 4;
    localparam int STACK_DEPTH = 6;
    localparam int BANK_SEL_W = 3;
    localparam logic [7:0] WIN_LO = 8'h40;
    localparam logic [7:0] WIN_HI = 8'h7F;
    localparam logic [7:0] BANK_HI = 8'h3F;
    localparam logic [7:0] IDX_LO = 8'h80;
    localparam logic [7:0] IDX_HI = 8'h83;
    localparam logic [7:0] RAM_LO = 8'h84;
    localparam logic [7:0] RAM_HI = 8'hBF;
    localparam logic [7:0] OFF_WIN_BASE = 8'hC9;
    localparam logic [7:0] OFF_BANK_SEL = 8'hE8;
    localparam int BIT_RAM_PAGE2 = 4;
    localparam int BIT_EE_PAGE1 = 1;
    localparam int BIT_EE_PAGE0 = 0;
    localparam logic [7:0] RST_DATA = 8'h00;
    localparam logic [11:0] RST_IPTR = 12'h000;
    localparam logic [11:0] IPTR_STEP = 12'h001;

    typedef enum logic [4:0] {
        SRC_NONE = 5'h01,
        SRC_INT  = 5'h02,
        SRC_PM   = 5'h04,
        SRC_BANK = 5'h08,
        SRC_PER  = 5'h10
    } src_e;

    // Locations at C0h upward that reach a peripheral, control or accumulator register
    function automatic logic per_mapped(input logic [7:0] a);
        logic m;
        m = (a >= 8'hC0 && a <= 8'hC2) || (a >= 8'hC4 && a <= 8'hC6) || (a == 8'hC8) ||
            (a >= 8'hCC && a <= 8'hCE) || (a >= 8'hD0 && a <= 8'hDD) ||
            (a >= 8'hE0 && a <= 8'hE2) || (a == 8'hEA) || (a == 8'hFF);
        return m;
    endfunction
endpackage

// >>> logic/data_space_window_decoder.sv
`timescale 1ns/1ps
module data_space_window_decoder #(
    parameter int RAM_BYTES = dsw_pkg::RAM_BYTES
) (
    // Clock, reset, enable
    input wire logic CLK,
    input wire logic SRST,
    input wire logic CE,
    // Core data access
    input wire logic [7:0] D_ADDR,
    input wire logic D_RD,
    input wire logic D_WR,
    input wire logic [7:0] D_WDATA,
    output logic [7:0] D_RDATA,
    output logic D_RVALID,
    // Program memory read port
    output logic [11:0] PM_ADDR,
    output logic PM_RD,
    input wire logic [7:0] PM_RDATA,
    // External readout and option
    input wire logic PROTECT,
    input wire logic EXT_RD,
    input wire logic [11:0] EXT_ADDR,
    output logic [7:0] EXT_RDATA,
    output logic EXT_RVALID,
    output logic EXT_DENIED,
    // Banked page and peripheral bus
    output logic [7:0] BUS_ADDR,
    output logic [7:0] BUS_WDATA,
    output logic BK_RD,
    output logic BK_WR,
    input wire logic [7:0] BK_RDATA,
    output logic PER_RD,
    output logic PER_WR,
    input wire logic [7:0] PER_RDATA,
    output logic RAM_PAGE2_SEL,
    output logic EE_PAGE1_SEL,
    output logic EE_PAGE0_SEL,
    // Instruction pointer control
    input wire logic PC_STEP,
    input wire logic PC_LOAD,
    input wire logic PC_CALL,
    input wire logic PC_RET,
    input wire logic [11:0] PC_TARGET,
    output logic [11:0] FETCH_ADDR
);
    // Address classes
    logic in_bank, in_win, in_idx, in_ram, is_wb, is_bs, in_per;
    logic [7:0] ram_off;
    assign in_bank = D_ADDR <= dsw_pkg::BANK_HI;
    assign in_win = D_ADDR >= dsw_pkg::WIN_LO && D_ADDR <= dsw_pkg::WIN_HI;
    assign in_idx = D_ADDR >= dsw_pkg::IDX_LO && D_ADDR <= dsw_pkg::IDX_HI;
    assign in_ram = D_ADDR >= dsw_pkg::RAM_LO && D_ADDR <= dsw_pkg::RAM_HI;
    assign is_wb = D_ADDR == dsw_pkg::OFF_WIN_BASE;
    assign is_bs = D_ADDR == dsw_pkg::OFF_BANK_SEL;
    assign in_per = dsw_pkg::per_mapped(D_ADDR);
    assign ram_off = D_ADDR - dsw_pkg::RAM_LO;
    // Write-only configuration, deliberately left out of reset
    logic [dsw_pkg::WIN_BASE_W-1:0] win_base_ff, nxt_win_base;
    logic [dsw_pkg::BANK_SEL_W-1:0] bank_ff, nxt_bank;
    always_comb begin
        nxt_win_base = win_base_ff;
        nxt_bank = bank_ff;
        if (D_WR && is_wb) begin
            nxt_win_base = D_WDATA[dsw_pkg::WIN_BASE_W-1:0];
        end
        if (D_WR && is_bs) begin
            nxt_bank = {D_WDATA[dsw_pkg::BIT_RAM_PAGE2], D_WDATA[dsw_pkg::BIT_EE_PAGE1],
                        D_WDATA[dsw_pkg::BIT_EE_PAGE0]};
        end
    end
    always_ff @(posedge CLK) begin
        if (CE) begin
            win_base_ff <= nxt_win_base;
            bank_ff <= nxt_bank;
        end
    end
    assign RAM_PAGE2_SEL = bank_ff[2];
    assign EE_PAGE1_SEL = bank_ff[1];
    assign EE_PAGE0_SEL = bank_ff[0];
    // Index, short-direct registers and general RAM
    logic [7:0] idx_ff [dsw_pkg::IDX_REGS];
    logic [7:0] nxt_idx [dsw_pkg::IDX_REGS];
    logic [7:0] ram_ff [RAM_BYTES];
    logic [7:0] nxt_ram [RAM_BYTES];
    always_comb begin
        nxt_idx = idx_ff;
        nxt_ram = ram_ff;
        if (D_WR && in_idx) begin
            nxt_idx[D_ADDR[1:0]] = D_WDATA;
        end
        if (D_WR && in_ram) begin
            nxt_ram[ram_off[5:0]] = D_WDATA;
        end
    end
    always_ff @(posedge CLK) begin
        if (CE) begin
            idx_ff <= nxt_idx;
            ram_ff <= nxt_ram;
        end
    end
    // Request stage
    dsw_pkg::src_e src_ff, nxt_src;
    logic rd_pend_ff, nxt_rd_pend;
    logic ext_pend_ff, nxt_ext_pend;
    logic ext_deny_ff, nxt_ext_deny;
    logic pm_rd_ff, nxt_pm_rd;
    logic [11:0] pm_addr_ff, nxt_pm_addr;
    logic bk_rd_ff, nxt_bk_rd, bk_wr_ff, nxt_bk_wr;
    logic per_rd_ff, nxt_per_rd, per_wr_ff, nxt_per_wr;
    logic [7:0] bus_addr_ff, nxt_bus_addr, bus_wdata_ff, nxt_bus_wdata;
    logic [7:0] int_data_ff, nxt_int_data;
    always_comb begin
        nxt_src = dsw_pkg::SRC_NONE;
        nxt_rd_pend = 1'b0;
        nxt_ext_pend = 1'b0;
        nxt_ext_deny = 1'b0;
        nxt_pm_rd = 1'b0;
        nxt_pm_addr = pm_addr_ff;
        nxt_bk_rd = 1'b0;
        nxt_bk_wr = 1'b0;
        nxt_per_rd = 1'b0;
        nxt_per_wr = 1'b0;
        nxt_bus_addr = bus_addr_ff;
        nxt_bus_wdata = bus_wdata_ff;
        nxt_int_data = int_data_ff;
        if (D_RD) begin
            nxt_rd_pend = 1'b1;
            if (in_win) begin
                nxt_src = dsw_pkg::SRC_PM;
                nxt_pm_rd = 1'b1;
                nxt_pm_addr = {win_base_ff, D_ADDR[dsw_pkg::WIN_OFS_W-1:0]};
            end else if (in_bank) begin
                nxt_src = dsw_pkg::SRC_BANK;
                nxt_bk_rd = 1'b1;
                nxt_bus_addr = D_ADDR;
            end else if (in_idx) begin
                nxt_src = dsw_pkg::SRC_INT;
                nxt_int_data = idx_ff[D_ADDR[1:0]];
            end else if (in_ram) begin
                nxt_src = dsw_pkg::SRC_INT;
                nxt_int_data = ram_ff[ram_off[5:0]];
            end else if (in_per) begin
                nxt_src = dsw_pkg::SRC_PER;
                nxt_per_rd = 1'b1;
                nxt_bus_addr = D_ADDR;
            end
        end else if (D_WR) begin
            // Window and write-only locations raise no strobe
            if (in_bank) begin
                nxt_bk_wr = 1'b1;
                nxt_bus_addr = D_ADDR;
                nxt_bus_wdata = D_WDATA;
            end else if (in_per) begin
                nxt_per_wr = 1'b1;
                nxt_bus_addr = D_ADDR;
                nxt_bus_wdata = D_WDATA;
            end
        end
        // Core window reads win the program memory port
        if (EXT_RD && !(D_RD && in_win)) begin
            nxt_ext_pend = 1'b1;
            if (PROTECT) begin
                nxt_ext_deny = 1'b1;
            end else begin
                nxt_pm_rd = 1'b1;
                nxt_pm_addr = EXT_ADDR;
            end
        end
    end
    always_ff @(posedge CLK) begin
        if (SRST) begin
            src_ff <= dsw_pkg::SRC_NONE;
            rd_pend_ff <= 1'b0;
            ext_pend_ff <= 1'b0;
            ext_deny_ff <= 1'b0;
            pm_rd_ff <= 1'b0;
            pm_addr_ff <= dsw_pkg::RST_IPTR;
            bk_rd_ff <= 1'b0;
            bk_wr_ff <= 1'b0;
            per_rd_ff <= 1'b0;
            per_wr_ff <= 1'b0;
            bus_addr_ff <= dsw_pkg::RST_DATA;
            bus_wdata_ff <= dsw_pkg::RST_DATA;
            int_data_ff <= dsw_pkg::RST_DATA;
        end else if (CE) begin
            src_ff <= nxt_src;
            rd_pend_ff <= nxt_rd_pend;
            ext_pend_ff <= nxt_ext_pend;
            ext_deny_ff <= nxt_ext_deny;
            pm_rd_ff <= nxt_pm_rd;
            pm_addr_ff <= nxt_pm_addr;
            bk_rd_ff <= nxt_bk_rd;
            bk_wr_ff <= nxt_bk_wr;
            per_rd_ff <= nxt_per_rd;
            per_wr_ff <= nxt_per_wr;
            bus_addr_ff <= nxt_bus_addr;
            bus_wdata_ff <= nxt_bus_wdata;
            int_data_ff <= nxt_int_data;
        end
    end
    assign PM_RD = pm_rd_ff;
    assign PM_ADDR = pm_addr_ff;
    assign BK_RD = bk_rd_ff;
    assign BK_WR = bk_wr_ff;
    assign PER_RD = per_rd_ff;
    assign PER_WR = per_wr_ff;
    assign BUS_ADDR = bus_addr_ff;
    assign BUS_WDATA = bus_wdata_ff;
    // Answer stage
    logic [7:0] rdata_ff, nxt_rdata, ext_rdata_ff, nxt_ext_rdata;
    logic rvalid_ff, ext_rvalid_ff, ext_denied_ff;
    always_comb begin
        nxt_rdata = rdata_ff;
        if (rd_pend_ff) begin
            case (src_ff)
                dsw_pkg::SRC_PM: nxt_rdata = PM_RDATA;
                dsw_pkg::SRC_BANK: nxt_rdata = BK_RDATA;
                dsw_pkg::SRC_PER: nxt_rdata = PER_RDATA;
                dsw_pkg::SRC_INT: nxt_rdata = int_data_ff;
                default: nxt_rdata = dsw_pkg::RST_DATA;
            endcase
        end
        nxt_ext_rdata = ext_rdata_ff;
        if (ext_pend_ff) begin
            nxt_ext_rdata = ext_deny_ff ? dsw_pkg::RST_DATA : PM_RDATA;
        end
    end
    always_ff @(posedge CLK) begin
        if (SRST) begin
            rdata_ff <= dsw_pkg::RST_DATA;
            rvalid_ff <= 1'b0;
            ext_rdata_ff <= dsw_pkg::RST_DATA;
            ext_rvalid_ff <= 1'b0;
            ext_denied_ff <= 1'b0;
        end else if (CE) begin
            rdata_ff <= nxt_rdata;
            rvalid_ff <= rd_pend_ff;
            ext_rdata_ff <= nxt_ext_rdata;
            ext_rvalid_ff <= ext_pend_ff;
            ext_denied_ff <= ext_pend_ff && ext_deny_ff;
        end
    end
    assign D_RDATA = rdata_ff;
    assign D_RVALID = rvalid_ff;
    assign EXT_RDATA = ext_rdata_ff;
    assign EXT_RVALID = ext_rvalid_ff;
    assign EXT_DENIED = ext_denied_ff;
    return_stack #(.DEPTH(dsw_pkg::STACK_DEPTH), .AW(dsw_pkg::PM_AW)) u_stack (
        .clk(CLK),
        .srst(SRST),
        .ce(CE),
        .step(PC_STEP),
        .load(PC_LOAD),
        .call(PC_CALL),
        .ret(PC_RET),
        .target(PC_TARGET),
        .iptr(FETCH_ADDR)
    );
    default clocking @(posedge CLK); endclocking
    default disable iff (SRST);
    sequence s_base_write;
        CE && D_WR && !D_RD && D_ADDR == dsw_pkg::OFF_WIN_BASE;
    endsequence
    sequence s_window_first;
        CE && D_RD && D_ADDR == dsw_pkg::WIN_LO;
    endsequence
    property p_window_step;
        logic [5:0] b;
        (s_base_write, b = D_WDATA[5:0]) ##1 s_window_first |=> PM_RD && PM_ADDR == {b, 6'h00};
    endproperty
    a_window_addr: assert property (CE && D_RD && in_win |=>
        PM_RD && PM_ADDR == {$past(win_base_ff), $past(D_ADDR[5:0])})
        else $error("window address wrong");
    a_window_step: assert property (p_window_step) else $error("window base step wrong");
    a_window_data: assert property (CE && D_RD && in_win ##1 CE |=>
        D_RVALID && D_RDATA == $past(PM_RDATA)) else $error("window data not returned");
    a_window_nowrite: assert property (CE && D_WR && !D_RD && !EXT_RD && in_win |=>
        !PM_RD && !BK_WR && !PER_WR) else $error("window write had effect");
    a_wo_read_zero: assert property (CE && D_RD && (is_wb || is_bs) ##1 CE |=>
        D_RVALID && D_RDATA == 8'h00) else $error("write-only read not zero");
    a_bank_strobe: assert property (CE && D_RD && in_bank |=>
        BK_RD && BUS_ADDR == $past(D_ADDR)) else $error("bank read not routed");
    a_bank_select: assert property (CE && D_WR && is_bs |=>
        RAM_PAGE2_SEL == $past(D_WDATA[4]) && EE_PAGE1_SEL == $past(D_WDATA[1]) &&
        EE_PAGE0_SEL == $past(D_WDATA[0])) else $error("bank select not taken");
    a_ram_readback: assert property (CE && D_WR && !D_RD && in_ram ##1
        CE && D_RD && D_ADDR == $past(D_ADDR) ##1 CE |=> D_RDATA == $past(D_WDATA, 3))
        else $error("ram readback wrong");
    a_reserved_quiet: assert property (CE && (D_RD || D_WR) &&
        D_ADDR >= 8'hC0 && !in_per |=> !PER_RD && !PER_WR && !BK_RD && !BK_WR)
        else $error("reserved access strobed");
    a_protect_deny: assert property (CE && EXT_RD && PROTECT && !(D_RD && in_win) ##1
        CE |=> EXT_RVALID && EXT_DENIED && EXT_RDATA == 8'h00)
        else $error("protected readout leaked");
endmodule

// >>> logic/return_stack.sv
`timescale 1ns/1ps
module return_stack #(
    parameter int DEPTH = dsw_pkg::STACK_DEPTH,
    parameter int AW = dsw_pkg::PM_AW
) (
    // Clock, reset and enable
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    // Flow control
    input wire logic step,
    input wire logic load,
    input wire logic call,
    input wire logic ret,
    input wire logic [AW-1:0] target,
    // Fetch address
    output logic [AW-1:0] iptr
);
    logic [AW-1:0] iptr_ff;
    logic [AW-1:0] nxt_iptr;
    logic [AW-1:0] stk_ff [DEPTH];
    logic [AW-1:0] nxt_stk [DEPTH];
    logic [AW-1:0] ret_addr;

    assign ret_addr = AW'(iptr_ff + dsw_pkg::IPTR_STEP);
    assign iptr = iptr_ff;

    // Priority: call, return, jump, step
    always_comb begin
        nxt_iptr = iptr_ff;
        if (call) begin
            nxt_iptr = target;
        end else if (ret) begin
            nxt_iptr = stk_ff[0];
        end else if (load) begin
            nxt_iptr = target;
        end else if (step) begin
            nxt_iptr = ret_addr;
        end
    end

    // Shifting stack; a push beyond six levels drops the oldest entry
    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++) begin : g_entry
            always_comb begin
                nxt_stk[gi] = stk_ff[gi];
                if (call) begin
                    nxt_stk[gi] = (gi == 0) ? ret_addr : stk_ff[(gi == 0) ? 0 : gi-1];
                end else if (ret) begin
                    nxt_stk[gi] = (gi == DEPTH-1) ? stk_ff[gi] : stk_ff[(gi == DEPTH-1) ? gi : gi+1];
                end
            end
            always_ff @(posedge clk) begin
                if (ce) begin
                    stk_ff[gi] <= nxt_stk[gi];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (srst) begin
            iptr_ff <= dsw_pkg::RST_IPTR;
        end else if (ce) begin
            iptr_ff <= nxt_iptr;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (srst);

    a_iptr_step: assert property (ce && step && !call && !ret && !load |=>
        iptr == AW'($past(iptr) + dsw_pkg::IPTR_STEP)) else $error("step did not advance");
    a_call_return: assert property (ce && call && !ret ##1 ce && ret && !call |=>
        iptr == AW'($past(iptr, 2) + dsw_pkg::IPTR_STEP)) else $error("return address lost");
    a_call_jump: assert property (ce && call |=> iptr == $past(target))
        else $error("call target not loaded");
endmodule

// >>> verif/data_space_window_decoder_tb.sv
`timescale 1ns/1ps
module data_space_window_decoder_tb;
    logic clk = 1'b0, srst = 1'b1, ce = 1'b1;
    logic [7:0] d_addr = 8'h00, d_wdata = 8'h00, d_rdata, pm_rdata, bus_addr, bus_wdata;
    logic [7:0] bk_rdata, per_rdata, ext_rdata, rdv;
    logic d_rd = 1'b0, d_wr = 1'b0, d_rvalid, pm_rd, bk_rd, bk_wr, per_rd, per_wr, rv;
    logic protect = 1'b0, ext_rd = 1'b0, ext_rvalid, ext_denied, p2, e1, e0;
    logic pc_step = 1'b0, pc_load = 1'b0, pc_call = 1'b0, pc_ret = 1'b0;
    logic [11:0] ext_addr = 12'h000, pc_target = 12'h000, pm_addr, fetch_addr, pa;
    logic [11:0] stk[1:6];
    logic [4:0] st;
    int n_mismatch = 0, n_compared = 0;

    always #50 clk = ~clk;

    data_space_window_decoder dut (.CLK(clk), .SRST(srst), .CE(ce), .D_ADDR(d_addr),
        .D_RD(d_rd), .D_WR(d_wr), .D_WDATA(d_wdata), .D_RDATA(d_rdata), .D_RVALID(d_rvalid),
        .PM_ADDR(pm_addr), .PM_RD(pm_rd), .PM_RDATA(pm_rdata), .PROTECT(protect),
        .EXT_RD(ext_rd), .EXT_ADDR(ext_addr), .EXT_RDATA(ext_rdata), .EXT_RVALID(ext_rvalid),
        .EXT_DENIED(ext_denied), .BUS_ADDR(bus_addr), .BUS_WDATA(bus_wdata), .BK_RD(bk_rd),
        .BK_WR(bk_wr), .BK_RDATA(bk_rdata), .PER_RD(per_rd), .PER_WR(per_wr),
        .PER_RDATA(per_rdata), .RAM_PAGE2_SEL(p2), .EE_PAGE1_SEL(e1), .EE_PAGE0_SEL(e0),
        .PC_STEP(pc_step), .PC_LOAD(pc_load), .PC_CALL(pc_call), .PC_RET(pc_ret),
        .PC_TARGET(pc_target), .FETCH_ADDR(fetch_addr));

    pm_bus_model u_model (.pm_addr(pm_addr), .pm_rd(pm_rd), .pm_rdata(pm_rdata),
        .bus_addr(bus_addr), .bk_rd(bk_rd), .per_rd(per_rd), .bk_rdata(bk_rdata),
        .per_rdata(per_rdata));

    function automatic logic [7:0] pmf(input logic [11:0] a);
        return a[7:0] ^ {a[11:8], 4'hA};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // One core access; strobes sampled in cycle 1, answer in cycle 2
    task automatic acc(input logic [7:0] a, input logic wr, input logic [7:0] wd);
        @(posedge clk);
        d_addr <= a;
        d_rd <= !wr;
        d_wr <= wr;
        d_wdata <= wd;
        @(posedge clk);
        d_rd <= 1'b0;
        d_wr <= 1'b0;
        #1;
        st = {pm_rd, bk_rd, bk_wr, per_rd, per_wr};
        pa = pm_addr;
        @(posedge clk);
        #1;
        rv = d_rvalid;
        rdv = d_rdata;
    endtask

    task automatic win(input logic [7:0] base, input logic [5:0] ofs);
        logic [11:0] e;
        e = {base[5:0], ofs};
        acc(8'hC9, 1'b1, base);
        acc({2'b01, ofs}, 1'b0, 8'h00);
        chk(pa, e);
        chk(rdv, pmf(e));
        chk({rv, st}, 6'b110000);
    endtask

    task automatic t_window();
        win(8'h00, 6'h00);
        chk(pa, 12'h000);
        win(8'h01, 6'h00);
        chk(pa, 12'h040);
        win(8'h3F, 6'h3F);
        chk(pa, 12'hFFF);
        win(8'hC2, 6'h05);
        chk(pa, 12'h085);
    endtask

    task automatic t_refused();
        acc(8'h45, 1'b1, 8'hEE);
        chk(st, 5'b00000);
        acc(8'hC9, 1'b0, 8'h00);
        chk({rv, st, rdv}, {6'b100000, 8'h00});
        acc(8'hC3, 1'b0, 8'h00);
        chk({rv, st, rdv}, {6'b100000, 8'h00});
    endtask

    task automatic t_bank();
        acc(8'hE8, 1'b1, 8'h10);
        chk({p2, e1, e0}, 3'b100);
        acc(8'hE8, 1'b1, 8'h03);
        chk({p2, e1, e0}, 3'b011);
        acc(8'h10, 1'b0, 8'h00);
        chk({st, bus_addr}, {5'b01000, 8'h10});
        chk(rdv, 8'h10 ^ 8'h5A);
        acc(8'h3F, 1'b1, 8'h9C);
        chk({st, bus_addr, bus_wdata}, {5'b00100, 8'h3F, 8'h9C});
        acc(8'hC0, 1'b0, 8'h00);
        chk({st, rdv}, {5'b00010, 8'hC0 ^ 8'hC3});
        acc(8'hFF, 1'b1, 8'h21);
        chk({st, bus_addr}, {5'b00001, 8'hFF});
    endtask

    task automatic t_ram();
        logic [7:0] al[3] = '{8'h80, 8'h83, 8'h84};
        acc(8'hBF, 1'b1, 8'h3C);
        foreach (al[i]) acc(al[i], 1'b1, al[i] ^ 8'h66);
        acc(8'hBF, 1'b0, 8'h00);
        chk({st, rdv}, {5'b00000, 8'h3C});
        foreach (al[i]) begin
            acc(al[i], 1'b0, 8'h00);
            chk({st, rdv}, {5'b00000, al[i] ^ 8'h66});
        end
    endtask

    // Write, then read on the very next edge, as the core may issue them
    task automatic b2b(input logic [7:0] wa, input logic [7:0] wd, input logic [7:0] ra);
        @(posedge clk);
        d_addr <= wa;
        d_wr <= 1'b1;
        d_wdata <= wd;
        @(posedge clk);
        d_addr <= ra;
        d_wr <= 1'b0;
        d_rd <= 1'b1;
        @(posedge clk);
        d_rd <= 1'b0;
        #1;
        pa = pm_addr;
        @(posedge clk);
        #1;
        rv = d_rvalid;
        rdv = d_rdata;
    endtask

    task automatic t_b2b();
        b2b(8'hA0, 8'h05, 8'hA0);
        chk({rv, rdv}, {1'b1, 8'h05});
        b2b(8'hC9, 8'h05, 8'h40);
        chk(pa, 12'h140);
        chk({rv, rdv}, {1'b1, pmf(12'h140)});
    endtask

    // Enable low: a write and a step offered meanwhile must leave no trace
    task automatic t_hold();
        logic [11:0] f;
        f = fetch_addr;
        @(posedge clk);
        ce <= 1'b0;
        pc_step <= 1'b1;
        d_addr <= 8'hC9;
        d_wr <= 1'b1;
        d_wdata <= 8'h3F;
        repeat (2) @(posedge clk);
        ce <= 1'b1;
        pc_step <= 1'b0;
        d_wr <= 1'b0;
        #1;
        chk(fetch_addr, f);
        acc(8'h40, 1'b0, 8'h00);
        chk(pa, 12'h140);
        chk({rv, rdv}, {1'b1, pmf(12'h140)});
    endtask

    task automatic t_reset_keep();
        acc(8'hC9, 1'b1, 8'h03);
        @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        acc(8'h45, 1'b0, 8'h00);
        chk(pa, 12'h0C5);
        chk({p2, e1, e0}, 3'b011);
    endtask

    task automatic t_ext(input logic pr);
        @(posedge clk);
        protect <= pr;
        ext_rd <= 1'b1;
        ext_addr <= 12'h123;
        @(posedge clk);
        ext_rd <= 1'b0;
        #1;
        chk(pm_rd, !pr);
        @(posedge clk);
        #1;
        chk({ext_rvalid, ext_denied}, {1'b1, pr});
        chk(ext_rdata, pr ? 8'h00 : pmf(12'h123));
        protect <= 1'b0;
    endtask

    task automatic pcop(input logic c, input logic r, input logic [11:0] t);
        @(posedge clk);
        pc_call <= c;
        pc_ret <= r;
        pc_step <= !c && !r;
        pc_target <= t;
        @(posedge clk);
        {pc_call, pc_ret, pc_step} <= 3'b000;
        #1;
    endtask

    task automatic t_stack();
        logic [11:0] pcm;
        pcm = fetch_addr;
        pcop(1'b0, 1'b0, 12'h000);
        chk(fetch_addr, pcm + 12'h001);
        for (int i = 1; i <= 6; i++) begin
            stk[i] = fetch_addr + 12'h001;
            pcop(1'b1, 1'b0, {i[3:0], 8'h00});
            chk(fetch_addr, {i[3:0], 8'h00});
        end
        for (int i = 6; i >= 1; i--) begin
            pcop(1'b0, 1'b1, 12'h000);
            chk(fetch_addr, stk[i]);
        end
        // Jump beats step, then a call answered by a return on the next edge
        @(posedge clk);
        pc_load <= 1'b1;
        pc_step <= 1'b1;
        pc_target <= 12'h3C5;
        @(posedge clk);
        pc_load <= 1'b0;
        pc_step <= 1'b0;
        pc_call <= 1'b1;
        pc_target <= 12'h2A0;
        #1;
        chk(fetch_addr, 12'h3C5);
        @(posedge clk);
        pc_call <= 1'b0;
        pc_ret <= 1'b1;
        #1;
        chk(fetch_addr, 12'h2A0);
        @(posedge clk);
        pc_ret <= 1'b0;
        #1;
        chk(fetch_addr, 12'h3C6);
    endtask

    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        #1;
        chk(fetch_addr, 12'h000);
        t_window();
        t_refused();
        t_bank();
        t_ram();
        t_b2b();
        t_hold();
        t_reset_keep();
        t_ext(1'b0);
        t_ext(1'b1);
        t_stack();
        test_done();
    end

    initial begin
        #(3000 * 100);
        n_mismatch++;
        test_done();
    end
endmodule

// >>> verif/pm_bus_model.sv
`timescale 1ns/1ps
module pm_bus_model (
    // Program memory
    input wire logic [11:0] pm_addr,
    input wire logic pm_rd,
    output logic [7:0] pm_rdata,
    // Banked and peripheral bus
    input wire logic [7:0] bus_addr,
    input wire logic bk_rd,
    input wire logic per_rd,
    output logic [7:0] bk_rdata,
    output logic [7:0] per_rdata
);
    logic [7:0] pmv;
    assign pmv = pm_addr[7:0] ^ {pm_addr[11:8], 4'hA};
    // Undriven cycles show the inverse so stale sampling is caught
    assign pm_rdata = pm_rd ? pmv : ~pmv;
    assign bk_rdata = bk_rd ? (bus_addr ^ 8'h5A) : ~(bus_addr ^ 8'h5A);
    assign per_rdata = per_rd ? (bus_addr ^ 8'hC3) : ~(bus_addr ^ 8'hC3);
endmodule
